// ===== rtl/csb_exec.v
// Execution slice of an 8-bit core: compare with constant, bit skips
// and conditional relative branches. Owns the program counter and the
// status register; the rest of the core may load either one.
// Assumes the core presents the addressed general register and I/O
// register values, and the next program word, with the instruction.
`timescale 1ns/10ps
`include "csb_map.vh"

module csb_exec (
   input wire i_clk,
   input wire i_sys_rst,
   input wire i_instr_valid,
   input wire [15:0] i_instr,
   input wire [15:0] i_next_word,
   input wire [7:0] i_reg_val,
   input wire [7:0] i_io_val,
   input wire i_pc_load,
   input wire [10:0] i_pc_data,
   input wire i_status_register_load,
   input wire [7:0] i_status_register_data,
   output reg o_ready,
   output reg o_done,
   output reg o_unknown,
   output reg [1:0] o_cycles,
   output reg [10:0] o_pc,
   output reg [7:0] o_status_register
);

   // One-hot sequencer states
   localparam ST_IDLE = 2'h1;
   localparam ST_WAIT = 2'h2;

   // Sequencer state
   reg [1:0] state;
   // Cycles still to wait before the last cycle of the instruction
   reg [1:0] wait_cnt;

   // Decoded instruction class
   wire is_cpi;
   wire is_skip_reg_bit_clear;
   wire is_skip_reg_bit_set;
   wire is_skip_io_bit_clear;
   wire is_skip_io_bit_set;
   wire is_branch_status_bit_set;
   wire is_branch_status_bit_clear;
   wire is_skip;
   wire is_branch;
   wire known;

   // Named branch aliases, only for clarity of the condition path
   wire branch_equal;
   wire branch_not_equal;
   wire branch_carry_set;
   wire branch_carry_clear;
   // Any of the four fixed-flag forms, and its own condition result
   wire fixed_form;
   wire fixed_hit;

   // Instruction fields
   wire [7:0] imm_k;
   wire [2:0] bit_sel;
   wire [10:0] rel_k;

   // Condition results
   wire reg_hit;
   wire io_hit;
   wire status_register_hit;
   wire skip_taken;
   wire branch_taken;
   wire next_two_word;

   // Compare flags
   wire cmp_h;
   wire cmp_v;
   wire cmp_n;
   wire cmp_z;
   wire cmp_c;

   // Handshake: an instruction is accepted only while ready
   wire take;

   // Next values for the architectural state
   reg [10:0] next_pc;
   reg [7:0] next_status_register;
   reg [1:0] next_cycles;

   assign take = i_instr_valid & o_ready;

   // Opcode classes
   assign is_cpi = (i_instr & `CSB_CPI_MASK) == `CSB_CPI_CODE;
   assign is_skip_reg_bit_clear = (i_instr & `CSB_SKR_MASK) == `CSB_SKIP_REG_BIT_CLEAR_CODE;
   assign is_skip_reg_bit_set = (i_instr & `CSB_SKR_MASK) == `CSB_SKIP_REG_BIT_SET_CODE;
   assign is_skip_io_bit_clear = (i_instr & `CSB_SKI_MASK) == `CSB_SKIP_IO_BIT_CLEAR_CODE;
   assign is_skip_io_bit_set = (i_instr & `CSB_SKI_MASK) == `CSB_SKIP_IO_BIT_SET_CODE;
   assign is_branch_status_bit_set = (i_instr & `CSB_BR_MASK) == `CSB_BRANCH_STATUS_BIT_SET_CODE;
   assign is_branch_status_bit_clear = (i_instr & `CSB_BR_MASK) == `CSB_BRANCH_STATUS_BIT_CLEAR_CODE;
   assign is_skip = is_skip_reg_bit_clear | is_skip_reg_bit_set | is_skip_io_bit_clear | is_skip_io_bit_set;
   assign is_branch = is_branch_status_bit_set | is_branch_status_bit_clear;
   assign known = is_cpi | is_skip | is_branch;

   // Fixed-flag branch forms are the status branches on Z or C
   assign branch_equal = is_branch_status_bit_set & (bit_sel == `CSB_FLAG_Z3);
   assign branch_not_equal = is_branch_status_bit_clear & (bit_sel == `CSB_FLAG_Z3);
   assign branch_carry_set = is_branch_status_bit_set & (bit_sel == `CSB_FLAG_C3);
   assign branch_carry_clear = is_branch_status_bit_clear & (bit_sel == `CSB_FLAG_C3);

   // Constant is split around the register field
   assign imm_k = {i_instr[`CSB_KH_MSB:`CSB_KH_LSB],
                   i_instr[`CSB_KL_MSB:`CSB_KL_LSB]};
   assign bit_sel = i_instr[`CSB_BIT_MSB:`CSB_BIT_LSB];
   // Seven-bit word offset, sign extended to the counter width
   assign rel_k = {{`CSB_K_EXT{i_instr[`CSB_K_MSB]}},
                   i_instr[`CSB_K_MSB:`CSB_K_LSB]};

   // General register bit test; polarity from the set/clear form
   csb_bit_test #(
      .W(8),
      .SW(3)
   ) u_reg_test (
      .i_value(i_reg_val),
      .i_sel(bit_sel),
      .i_want(is_skip_reg_bit_set),
      .o_hit(reg_hit)
   );

   // I/O register bit test
   csb_bit_test #(
      .W(8),
      .SW(3)
   ) u_io_test (
      .i_value(i_io_val),
      .i_sel(bit_sel),
      .i_want(is_skip_io_bit_set),
      .o_hit(io_hit)
   );

   // Status register bit test; set form wants a one
   csb_bit_test #(
      .W(8),
      .SW(3)
   ) u_status_register_test (
      .i_value(o_status_register),
      .i_sel(bit_sel),
      .i_want(is_branch_status_bit_set),
      .o_hit(status_register_hit)
   );

   // Compare against the constant
   csb_cmp_flags u_cmp (
      .i_rd(i_reg_val),
      .i_k(imm_k),
      .o_h(cmp_h),
      .o_v(cmp_v),
      .o_n(cmp_n),
      .o_z(cmp_z),
      .o_c(cmp_c)
   );

   // Register skips use the register test, I/O skips the I/O test
   assign skip_taken = ((is_skip_reg_bit_clear | is_skip_reg_bit_set) & reg_hit) |
                       ((is_skip_io_bit_clear | is_skip_io_bit_set) & io_hit);
   // Fixed-flag forms test Z or C directly; the result must agree with
   // the generic status test, which covers every other status bit
   assign fixed_form = branch_equal | branch_not_equal |
                       branch_carry_set | branch_carry_clear;
   assign fixed_hit =
      (branch_equal & o_status_register[`CSB_FLAG_Z]) |
      (branch_not_equal & ~o_status_register[`CSB_FLAG_Z]) |
      (branch_carry_set & o_status_register[`CSB_FLAG_C]) |
      (branch_carry_clear & ~o_status_register[`CSB_FLAG_C]);
   // Every other status bit goes through the generic test
   assign branch_taken = fixed_form ? fixed_hit :
                         (is_branch & status_register_hit);

   // A skipped two-word instruction costs one more word and cycle
   assign next_two_word =
      ((i_next_word & `CSB_LDST_MASK) == `CSB_LDS_CODE) |
      ((i_next_word & `CSB_LDST_MASK) == `CSB_STS_CODE) |
      ((i_next_word & `CSB_JC_MASK) == `CSB_JC_CODE);

   // Next program counter and cycle count
   always @* begin
      next_pc = o_pc + `CSB_PC_ONE;
      next_cycles = `CSB_CYC_ONE;
      if (!known) begin
         // Not ours: hold the counter; a core load on the same edge is ignored
         next_pc = o_pc;
      end else if (is_skip) begin
         if (skip_taken) begin
            if (next_two_word) begin
               next_pc = o_pc + `CSB_PC_THREE;
               next_cycles = `CSB_CYC_THREE;
            end else begin
               next_pc = o_pc + `CSB_PC_TWO;
               next_cycles = `CSB_CYC_TWO;
            end
         end
      end else if (is_branch) begin
         if (branch_taken) begin
            // Relative target wraps within the counter width
            next_pc = o_pc + rel_k + `CSB_PC_ONE;
            next_cycles = `CSB_CYC_TWO;
         end
      end
   end

   // Next status register: compare updates five flags only
   always @* begin
      next_status_register = o_status_register;
      if (take & is_cpi) begin
         next_status_register[`CSB_FLAG_H] = cmp_h;
         next_status_register[`CSB_FLAG_V] = cmp_v;
         next_status_register[`CSB_FLAG_N] = cmp_n;
         next_status_register[`CSB_FLAG_Z] = cmp_z;
         next_status_register[`CSB_FLAG_C] = cmp_c;
      end else if (i_status_register_load) begin
         // Core write when this slice does not touch the flags
         next_status_register = i_status_register_data;
      end
   end

   // Status register; skips and branches never write it
   always @(posedge i_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         o_status_register <= `CSB_STATUS_REGISTER_RST;
      end else begin
         o_status_register <= next_status_register;
      end
   end

   // Program counter: own update wins over a core load
   always @(posedge i_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         o_pc <= `CSB_PC_RST;
      end else if (take) begin
         o_pc <= next_pc;
      end else if (i_pc_load) begin
         o_pc <= i_pc_data;
      end
   end

   // Sequencer: holds off new work for the extra cycles
   // The counter moves at accept time so the fetch side can
   // follow at once; the wait only models the cycle cost.
   always @(posedge i_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         state <= ST_IDLE;
         wait_cnt <= `CSB_CYC_ZERO;
         o_ready <= 1'b1;
         o_done <= 1'b0;
         o_unknown <= 1'b0;
         o_cycles <= `CSB_CYC_ZERO;
      end else begin
         o_done <= 1'b0;
         o_unknown <= 1'b0;
         case (state)
            ST_IDLE: begin
               if (take) begin
                  o_cycles <= next_cycles;
                  o_unknown <= ~known;
                  if (next_cycles == `CSB_CYC_ONE) begin
                     // Single-cycle: done right away, stay ready
                     o_done <= 1'b1;
                  end else begin
                     // Multi-cycle: drop ready for the remainder
                     state <= ST_WAIT;
                     o_ready <= 1'b0;
                     wait_cnt <= next_cycles - `CSB_CYC_TWO;
                  end
               end
            end
            ST_WAIT: begin
               if (wait_cnt == `CSB_CYC_ZERO) begin
                  // Last cycle of the instruction
                  state <= ST_IDLE;
                  o_ready <= 1'b1;
                  o_done <= 1'b1;
               end else begin
                  wait_cnt <= wait_cnt - `CSB_CYC_ONE;
               end
            end
            default: begin
               // Recover from an illegal code
               state <= ST_IDLE;
               o_ready <= 1'b1;
               wait_cnt <= `CSB_CYC_ZERO;
            end
         endcase
      end
   end

endmodule // csb_exec

// ===== rtl/csb_map.vh
// Constants for the compare, skip and branch execution slice.
// Assumes 16-bit instruction words and an 11-bit word program counter.
`ifndef CSB_MAP_VH
`define CSB_MAP_VH

// Opcode masks and match values
`define CSB_CPI_MASK 16'hF000
`define CSB_CPI_CODE 16'h3000
`define CSB_SKR_MASK 16'hFE08
`define CSB_SKIP_REG_BIT_CLEAR_CODE 16'hFC00
`define CSB_SKIP_REG_BIT_SET_CODE 16'hFE00
`define CSB_SKI_MASK 16'hFF00
`define CSB_SKIP_IO_BIT_CLEAR_CODE 16'h9900
`define CSB_SKIP_IO_BIT_SET_CODE 16'h9B00
`define CSB_BR_MASK 16'hFC00
`define CSB_BRANCH_STATUS_BIT_SET_CODE 16'hF000
`define CSB_BRANCH_STATUS_BIT_CLEAR_CODE 16'hF400

// Two-word instructions (direct load/store, long jump/call)
`define CSB_LDST_MASK 16'hFE0F
`define CSB_LDS_CODE 16'h9000
`define CSB_STS_CODE 16'h9200
`define CSB_JC_MASK 16'hFE0C
`define CSB_JC_CODE 16'h940C

// Field positions inside the instruction word
`define CSB_KH_MSB 11
`define CSB_KH_LSB 8
`define CSB_KL_MSB 3
`define CSB_KL_LSB 0
`define CSB_BIT_MSB 2
`define CSB_BIT_LSB 0
`define CSB_K_MSB 9
`define CSB_K_LSB 3
`define CSB_K_EXT 4

// Status register bit positions
`define CSB_FLAG_C 0
`define CSB_FLAG_Z 1
`define CSB_FLAG_N 2
`define CSB_FLAG_V 3
`define CSB_FLAG_H 5
`define CSB_FLAG_C3 3'h0
`define CSB_FLAG_Z3 3'h1

// Program counter steps and reset values
`define CSB_PC_W 11
`define CSB_PC_ONE 11'h001
`define CSB_PC_TWO 11'h002
`define CSB_PC_THREE 11'h003
`define CSB_PC_RST 11'h000
`define CSB_STATUS_REGISTER_RST 8'h00

// Execution cycle counts
`define CSB_CYC_ZERO 2'h0
`define CSB_CYC_ONE 2'h1
`define CSB_CYC_TWO 2'h2
`define CSB_CYC_THREE 2'h3

`endif

// ===== rtl/csb_bit_test.v
// Single bit test: selects one bit of a word and compares it to a level.
// Assumes operands are stable in the cycle the instruction is taken.
`timescale 1ns/10ps

module csb_bit_test #(
   parameter W = 8,
   parameter SW = 3
) (
   input wire [W-1:0] i_value,
   input wire [SW-1:0] i_sel,
   input wire i_want,
   output wire o_hit
);

   // High when the chosen bit equals the wanted level
   assign o_hit = (i_value[i_sel] == i_want);

endmodule // csb_bit_test

// ===== rtl/csb_cmp_flags.v
// Compare unit: subtracts an 8-bit constant and derives the flags.
// Assumes the register operand is delivered by the core's register file.
`timescale 1ns/10ps

module csb_cmp_flags (
   input wire [7:0] i_rd,
   input wire [7:0] i_k,
   output wire o_h,
   output wire o_v,
   output wire o_n,
   output wire o_z,
   output wire o_c
);

   // Difference, kept only for the flags
   wire [7:0] res;

   assign res = i_rd - i_k;
   // Borrow out of bit 3
   assign o_h = (~i_rd[3] & i_k[3]) | (i_k[3] & res[3]) | (res[3] & ~i_rd[3]);
   // Signed overflow of the subtraction
   assign o_v = (i_rd[7] & ~i_k[7] & ~res[7]) | (~i_rd[7] & i_k[7] & res[7]);
   assign o_n = res[7];
   assign o_z = (res == 8'h00);
   // Borrow out of bit 7
   assign o_c = (~i_rd[7] & i_k[7]) | (i_k[7] & res[7]) | (res[7] & ~i_rd[7]);

endmodule // csb_cmp_flags

// ===== test/csb_exec_props.sv
// Checker for the compare, skip and branch slice.
// Sees only the ports of csb_exec; bound at the foot of this file.
`timescale 1ns/10ps
module csb_exec_props (
   input wire i_clk,
   input wire i_sys_rst,
   input wire i_instr_valid,
   input wire [15:0] i_instr,
   input wire [15:0] i_next_word,
   input wire [7:0] i_reg_val,
   input wire [7:0] i_io_val,
   input wire i_status_register_load,
   input wire o_ready,
   input wire o_done,
   input wire [1:0] o_cycles,
   input wire [10:0] o_pc,
   input wire [7:0] o_status_register
);
   // Accepted word; a same-edge status load is left out of the checks
   wire tk = i_instr_valid && o_ready && !i_status_register_load;
   wire cmp = tk && i_instr[15:12] == 4'h3;
   wire [7:0] k = {i_instr[11:8], i_instr[3:0]};
   wire rb = i_reg_val[i_instr[2:0]];
   wire ib = i_io_val[i_instr[2:0]];
   wire sb = o_status_register[i_instr[2:0]];
   // A skipped long jump/call, or direct load/store with bit 8 clear, costs one more word
   wire two = ((i_next_word & 16'hFC0F) == 16'h9000 && !i_next_word[8]) ||
      (i_next_word & 16'hFE0C) == 16'h940C;
   wire [10:0] step = two ? 11'h003 : 11'h002;
   // Relative target with the offset sign extended
   wire [10:0] tgt = o_pc + {{4{i_instr[9]}}, i_instr[9:3]} + 11'h001;
   wire br = tk && (i_instr & 16'hF800) == 16'hF000;
   wire hit = i_instr[10] ? !sb : sb;
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (i_sys_rst);

   property p_cmp_pc;
      cmp |=> o_done && o_cycles == 2'h1 && o_pc == $past(o_pc) + 11'h001;
   endproperty
   a_cmp_pc: assert property (p_cmp_pc)
      else $error("compare step or cost wrong");
   property p_cmp_zc;
      cmp |=> o_status_register[1] == ($past(i_reg_val) == $past(k)) &&
         o_status_register[0] == ($past(i_reg_val) < $past(k));
   endproperty
   a_cmp_zc: assert property (p_cmp_zc)
      else $error("compare zero or carry wrong");
   property p_skip_reg_bit_clear;
      tk && (i_instr & 16'hFE08) == 16'hFC00 && !rb |=>
         o_pc == $past(o_pc) + $past(step) && o_status_register == $past(o_status_register);
   endproperty
   a_skip_reg_bit_clear: assert property (p_skip_reg_bit_clear)
      else $error("register clear skip wrong");
   property p_skip_reg_bit_set;
      tk && (i_instr & 16'hFE08) == 16'hFE00 && rb |=>
         o_pc == $past(o_pc) + $past(step) && o_status_register == $past(o_status_register);
   endproperty
   a_skip_reg_bit_set: assert property (p_skip_reg_bit_set)
      else $error("register set skip wrong");
   property p_skip_io_bit_clear;
      tk && i_instr[15:8] == 8'h99 && !ib |=>
         o_pc == $past(o_pc) + $past(step) && o_status_register == $past(o_status_register);
   endproperty
   a_skip_io_bit_clear: assert property (p_skip_io_bit_clear)
      else $error("io clear skip wrong");
   property p_skip_io_bit_set;
      tk && i_instr[15:8] == 8'h9B && ib |=>
         o_pc == $past(o_pc) + $past(step) && o_status_register == $past(o_status_register);
   endproperty
   a_skip_io_bit_set: assert property (p_skip_io_bit_set)
      else $error("io set skip wrong");
   property p_br_set;
      br && !i_instr[10] && sb |=> o_pc == $past(tgt) && o_cycles == 2'h2
         ##1 o_done;
   endproperty
   a_br_set: assert property (p_br_set)
      else $error("set branch wrong");
   property p_br_clr;
      br && i_instr[10] && !sb |=> o_pc == $past(tgt) && !o_ready
         ##1 o_done && o_ready;
   endproperty
   a_br_clr: assert property (p_br_clr)
      else $error("clear branch wrong");
   property p_br_no;
      br && !hit |=> o_done && o_cycles == 2'h1 &&
         o_pc == $past(o_pc) + 11'h001 && o_status_register == $past(o_status_register);
   endproperty
   a_br_no: assert property (p_br_no)
      else $error("untaken branch wrong");
endmodule // csb_exec_props

bind csb_exec csb_exec_props u_props (.i_clk(i_clk), .i_sys_rst(i_sys_rst),
   .i_instr_valid(i_instr_valid), .i_instr(i_instr),
   .i_next_word(i_next_word), .i_reg_val(i_reg_val), .i_io_val(i_io_val),
   .i_status_register_load(i_status_register_load), .o_ready(o_ready), .o_done(o_done),
   .o_cycles(o_cycles), .o_pc(o_pc), .o_status_register(o_status_register));

// ===== test/csb_exec_test.sv
// Self-checking bench for the compare, skip and branch slice.
// Drives csb_exec directly at the falling clock edge.
`timescale 1ns/10ps
module csb_exec_test;
   logic i_clk = 1'b0;
   logic i_sys_rst = 1'b1;
   logic i_instr_valid = 1'b0;
   logic [15:0] i_instr = 16'h0000;
   logic [15:0] i_next_word = 16'h0000;
   logic [7:0] i_reg_val = 8'h00;
   logic [7:0] i_io_val = 8'h00;
   logic i_pc_load = 1'b0;
   logic [10:0] i_pc_data = 11'h000;
   logic i_status_register_load = 1'b0;
   logic [7:0] i_status_register_data = 8'h00;
   wire o_ready, o_done, o_unknown;
   wire [1:0] o_cycles;
   wire [10:0] o_pc;
   wire [7:0] o_status_register;
   integer miscompares = 0;
   integer n_tests = 0;
   logic [10:0] mpc; // Model program counter
   logic [7:0] msr; // Model status register
   logic munk = 1'b0; // Expected unknown-word flag
   always #2.5 i_clk = ~i_clk;
   csb_exec u_dut (.i_clk(i_clk), .i_sys_rst(i_sys_rst),
      .i_instr_valid(i_instr_valid), .i_instr(i_instr),
      .i_next_word(i_next_word), .i_reg_val(i_reg_val), .i_io_val(i_io_val),
      .i_pc_load(i_pc_load), .i_pc_data(i_pc_data),
      .i_status_register_load(i_status_register_load), .i_status_register_data(i_status_register_data),
      .o_ready(o_ready), .o_done(o_done), .o_unknown(o_unknown),
      .o_cycles(o_cycles), .o_pc(o_pc), .o_status_register(o_status_register));

   task end_sim;
      begin
         $display("tests %0d miscompares %0d", n_tests, miscompares);
         if (miscompares == 0 && n_tests > 0) $display("[ PASS ]");
         else $display("[ FAIL ]");
         $finish;
      end
   endtask

   task chk(input [8*6:1] nm, input [15:0] e, input [15:0] g);
      begin
         n_tests = n_tests + 1;
         if (g !== e) begin
            miscompares = miscompares + 1;
            $display("[FAIL] %0s exp %h got %h", nm, e, g);
         end
      end
   endtask

   // Preload program counter and status together in one edge
   task setst(input [10:0] pc, input [7:0] sr);
      begin
         i_pc_load = 1'b1;
         i_pc_data = pc;
         i_status_register_load = 1'b1;
         i_status_register_data = sr;
         @(negedge i_clk);
         i_pc_load = 1'b0;
         i_status_register_load = 1'b0;
         mpc = pc;
         msr = sr;
      end
   endtask

   // One word; operands turn stale after the take edge on purpose
   task exec(input [15:0] ins, input [15:0] nw, input [7:0] rv,
      input [7:0] iv, input [1:0] ec, input [10:0] ep, input [7:0] es);
      integer n;
      begin
         i_instr_valid = 1'b1;
         i_instr = ins;
         i_next_word = nw;
         i_reg_val = rv;
         i_io_val = iv;
         @(negedge i_clk);
         i_instr_valid = 1'b0;
         i_reg_val = ~rv;
         i_io_val = ~iv;
         chk("pc", {5'h00, ep}, {5'h00, o_pc});
         chk("status_register", {8'h00, es}, {8'h00, o_status_register});
         chk("cycles", {14'h0, ec}, {14'h0, o_cycles});
         chk("ready", {15'h0000, ec == 2'h1}, {15'h0000, o_ready});
         chk("unk", {15'h0000, munk}, {15'h0000, o_unknown});
         n = 1;
         // Count cycles up to the completion pulse, bounded
         while (o_done !== 1'b1 && n < 8) begin
            @(negedge i_clk);
            n = n + 1;
         end
         chk("done", {14'h0, ec}, n[15:0]);
         if (n == 8) end_sim;
         mpc = ep;
         msr = es;
      end
   endtask

   // Compare with borrow, overflow, half borrow and equal cases
   task t_cmp;
      logic [7:0] d, k, r, s;
      integer i;
      begin
         setst(11'h7FF, 8'hD5);
         for (i = 0; i < 6; i = i + 1) begin
            d = 8'h47 * i;
            k = 8'h2D * i;
            r = d - k;
            s = msr & 8'hD0;
            s[0] = d < k;
            s[1] = r == 8'h00;
            s[2] = r[7];
            s[3] = (d[7] != k[7]) && (r[7] != d[7]);
            s[5] = d[3:0] < k[3:0];
            exec({4'h3, k[7:4], i[3:0], k[3:0]}, 16'h0000, d, 8'h00,
               2'h1, mpc + 11'h001, s);
         end
      end
   endtask

   // All four skips, both bit levels, one and two word followers
   task t_skip;
      integer op, v, w;
      logic [15:0] ins, nw;
      logic [7:0] val;
      logic [1:0] c;
      begin
         setst(11'h100, 8'hA5);
         for (op = 0; op < 4; op = op + 1)
            for (v = 0; v < 2; v = v + 1)
               for (w = 0; w < 2; w = w + 1) begin
                  ins = op == 0 ? 16'hFD56 : op == 1 ? 16'hFF56 :
                     op == 2 ? 16'h9956 : 16'h9B56;
                  nw = w ? (op[1] ? 16'h940C : 16'h9200) : 16'h9201;
                  val = v ? 8'h40 : 8'hBF;
                  c = v[0] == op[0] ? (w ? 2'h3 : 2'h2) : 2'h1;
                  exec(ins, nw, op[1] ? ~val : val, op[1] ? val : ~val,
                     c, mpc + {9'h000, c}, msr);
               end
      end
   endtask

   // Every status bit, set and clear forms, extreme offsets
   task t_branch;
      integer s, b, j;
      logic [6:0] k;
      logic [7:0] sv;
      logic [10:0] ep;
      logic tk;
      begin
         for (s = 0; s < 8; s = s + 1)
            for (b = 0; b < 2; b = b + 1)
               for (j = 0; j < 2; j = j + 1) begin
                  k = j ? 7'h40 : 7'h3F;
                  sv = j ? 8'h5A : 8'hA5;
                  tk = b ? !sv[s] : sv[s];
                  setst(11'h020, sv);
                  // Taken target wraps within the counter width
                  ep = tk ? mpc + {{4{k[6]}}, k} + 11'h001 : mpc + 11'h001;
                  exec({5'h1E, b[0], k, s[2:0]},
                     16'h0000, 8'h00, 8'h00,
                     tk ? 2'h2 : 2'h1, ep, sv);
               end
      end
   endtask

   // Near-miss words must be refused: counter and flags left alone
   task t_unknown;
      begin
         setst(11'h155, 8'hFF);
         munk = 1'b1;
         exec(16'hFC08, 16'h9200, 8'h00, 8'h00, 2'h1, mpc, msr);
         exec(16'hF800, 16'h0000, 8'h00, 8'h00, 2'h1, mpc, msr);
         munk = 1'b0;
      end
   endtask

   // Reset in the middle of a taken branch, then a compare at once
   task t_reset;
      begin
         setst(11'h0AA, 8'h02);
         i_instr_valid = 1'b1;
         i_instr = 16'hF009; // Equal branch, offset one, zero flag set
         @(negedge i_clk);
         i_instr_valid = 1'b0;
         i_sys_rst = 1'b1;
         @(negedge i_clk);
         chk("ready", 16'h0001, {15'h0000, o_ready});
         chk("pc", 16'h0000, {5'h00, o_pc});
         chk("status_register", 16'h0000, {8'h00, o_status_register});
         chk("cycles", 16'h0000, {14'h0000, o_cycles});
         i_sys_rst = 1'b0;
         mpc = 11'h000;
         msr = 8'h00;
         exec(16'h3000, 16'h0000, 8'h00, 8'h00, 2'h1, 11'h001, 8'h02);
      end
   endtask

   initial begin
      repeat (16) @(negedge i_clk);
      i_sys_rst = 1'b0;
      @(negedge i_clk);
      t_cmp;
      t_skip;
      t_reset;
      t_unknown;
      t_branch;
      end_sim;
   end
endmodule // csb_exec_test
